/* cmdt_mailbox.sv */
// command mailbox of the serial interface with read date/time and date keeping
`include "cmdt_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module cmdt_mailbox #(
   parameter int unsigned MS_CYCLES    = `CMDT_MS_CYCLES,
   parameter int unsigned SYNC_SECONDS = `CMDT_SYNC_SECONDS
) (
   input  wire logic                clock_in,
   input  wire logic                rst_n_in,
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   input  wire logic [15:0]         reg_num_in,
   input  wire logic [15:0]         reg_wdata_in,
   output var  logic [15:0]         reg_rdata_out,
   output var  logic                reg_rvalid_out,
   output var  logic                cmd_done_out,
   input  wire logic                set_fc43_in,
   input  wire logic                set_abs_in,
   input  wire cmdt_pkg::cmdt_time_t set_value_in,
   input  wire cmdt_pkg::cmdt_mode_t mode_in,
   output var  logic                synced_out,
   output var  logic                bcast_valid_out,
   output var  cmdt_pkg::cmdt_time_t bcast_time_out,
   input  wire logic                event_in,
   output var  logic                stamp_valid_out,
   output var  cmdt_pkg::cmdt_time_t stamp_out
);

   // days in a month, leap years every fourth year from 2000
   function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
      case (mon)
         8'h02:   days_in_month = (yr[1:0] == 2'b00) ? 8'h1D : 8'h1C;
         8'h04, 8'h06, 8'h09, 8'h0B: days_in_month = 8'h1E;
         default: days_in_month = 8'h1F;
      endcase
   endfunction

   // calendar advanced by one millisecond
   function automatic cmdt_pkg::cmdt_time_t next_ms(input cmdt_pkg::cmdt_time_t t);
      cmdt_pkg::cmdt_time_t r;
      r = t;
      if (t.msec != `CMDT_MS_MAX) begin
         r.msec = t.msec + 16'h0001;
      end else begin
         r.msec = 16'h0000;
         if (t.second != 8'h3B) begin
            r.second = t.second + 8'h01;
         end else begin
            r.second = 8'h00;
            if (t.minute != 8'h3B) begin
               r.minute = t.minute + 8'h01;
            end else begin
               r.minute = 8'h00;
               if (t.hour != 8'h17) begin
                  r.hour = t.hour + 8'h01;
               end else begin
                  r.hour = 8'h00;
                  if (t.day < days_in_month(t.month, t.year)) begin
                     r.day = t.day + 8'h01;
                  end else begin
                     r.day = 8'h01;
                     if (t.month != 8'h0C) begin
                        r.month = t.month + 8'h01;
                     end else begin
                        r.month = 8'h01;
                        r.year  = t.year + 8'h01;
                     end
                  end
               end
            end
         end
      end
      return r;
   endfunction

   logic [15:0]           cmd_buf [0:19];
   logic [19:0]           written;
   cmdt_pkg::cmdt_state_t state;
   logic [15:0]           exec_code;
   logic [15:0]           result;
   logic [15:0]           data_len;
   cmdt_pkg::cmdt_time_t  snap;
   cmdt_pkg::cmdt_time_t  now;
   logic [14:0]           ms_cnt;
   logic                  ms_tick;
   logic                  sec_roll;
   logic [12:0]           sync_age;
   logic [15:0]           buf_idx;
   logic                  in_buf;
   logic                  accept;
   logic                  set_req;
   logic [7:0]            next_err;

   assign buf_idx  = reg_num_in - `CMDT_REG_CMD_BASE;
   assign in_buf   = (reg_num_in >= `CMDT_REG_CMD_BASE) && (reg_num_in <= `CMDT_REG_CMD_LAST);
   // buffer taken when its last word lands and the other nineteen were written
   assign accept   = reg_wr_in && (reg_num_in == `CMDT_REG_CMD_LAST)
                     && (state == cmdt_pkg::CMDT_IDLE)
                     && (&written[18:0]);
   assign set_req  = set_fc43_in || set_abs_in;
   assign sec_roll = ms_tick && (now.msec == `CMDT_MS_MAX);

   // command buffer capture, refused while a command runs
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         written <= 20'h0_0000;
      end else if (accept) begin
         written <= 20'h0_0000;
      end else if (reg_wr_in && in_buf && state == cmdt_pkg::CMDT_IDLE) begin
         written[buf_idx[4:0]] <= 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (reg_wr_in && in_buf && state == cmdt_pkg::CMDT_IDLE) begin
         cmd_buf[buf_idx[4:0]] <= reg_wdata_in;
      end
   end

   // error code from the captured buffer
   always_comb begin
      next_err = `CMDT_ERR_NONE;
      if (cmd_buf[0] != `CMDT_CODE_READ_TIME) begin
         next_err = `CMDT_ERR_UNKNOWN;
      end else if (cmd_buf[1] != `CMDT_FIXED_LEN) begin
         next_err = `CMDT_ERR_RANGE;
      end else if (cmd_buf[2] != `CMDT_DEST_SERIAL) begin
         next_err = `CMDT_ERR_RANGE;
      end else if (cmd_buf[17] != `CMDT_SETUP_0 || cmd_buf[18] != `CMDT_SETUP_1
                   || cmd_buf[19] != `CMDT_SETUP_2) begin
         next_err = `CMDT_ERR_RANGE;
      end
   end

   // command sequencer
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state <= cmdt_pkg::CMDT_IDLE;
      end else begin
         case (state)
            cmdt_pkg::CMDT_IDLE: if (accept) state <= cmdt_pkg::CMDT_BUSY;
            cmdt_pkg::CMDT_BUSY: state <= cmdt_pkg::CMDT_DONE;
            cmdt_pkg::CMDT_DONE: state <= cmdt_pkg::CMDT_IDLE;
            default:             state <= cmdt_pkg::CMDT_IDLE;
         endcase
      end
   end

   // result registers: busy at acceptance, final values at completion
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         exec_code <= 16'h0000;
         result    <= 16'h0000;
         data_len  <= 16'h0000;
         snap      <= '0;
      end else if (accept) begin
         result <= `CMDT_STATUS_BUSY;
      end else if (state == cmdt_pkg::CMDT_BUSY) begin
         exec_code <= cmd_buf[0];
         result    <= {cmd_buf[2][15:8], next_err};
         if (next_err == `CMDT_ERR_NONE) begin
            data_len <= `CMDT_TIME_DATA_LEN;
            snap     <= now;
         end else begin
            data_len <= 16'h0000;
         end
      end
   end

   assign cmd_done_out = (state == cmdt_pkg::CMDT_DONE);

   // register reads, answered one cycle later
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         reg_rdata_out  <= 16'h0000;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            case (reg_num_in)
               `CMDT_REG_EXEC_CODE: reg_rdata_out <= exec_code;
               `CMDT_REG_RESULT:    reg_rdata_out <= result;
               `CMDT_REG_DATA_LEN:  reg_rdata_out <= data_len;
               `CMDT_REG_MONTH_DAY: reg_rdata_out <= {snap.month, snap.day};
               `CMDT_REG_YEAR_HOUR: reg_rdata_out <= {snap.year, snap.hour};
               `CMDT_REG_MIN_SEC:   reg_rdata_out <= {snap.minute, snap.second};
               `CMDT_REG_MSEC:      reg_rdata_out <= snap.msec;
               default:             reg_rdata_out <= 16'h0000;
            endcase
         end
      end
   end

   // millisecond enable from the system clock
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ms_cnt  <= 15'h0000;
         ms_tick <= 1'b0;
      end else if (ms_cnt == 15'(MS_CYCLES - 1)) begin
         ms_cnt  <= 15'h0000;
         ms_tick <= 1'b1;
      end else begin
         ms_cnt  <= ms_cnt + 15'h0001;
         ms_tick <= 1'b0;
      end
   end

   // local calendar, external set wins over the tick
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         now <= '{year: 8'h00, month: 8'h01, day: 8'h01, default: '0};
      end else if (set_req) begin
         now <= set_value_in;
      end else if (ms_tick) begin
         now <= next_ms(now);
      end
   end

   // age of the last external synchronization in seconds
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sync_age   <= 13'h0000;
         synced_out <= 1'b0;
      end else if (set_req) begin
         sync_age   <= 13'h0000;
         synced_out <= 1'b1;
      end else if (sec_roll && synced_out) begin
         if (sync_age == 13'(SYNC_SECONDS - 1)) begin
            synced_out <= 1'b0;
         end else begin
            sync_age <= sync_age + 13'h0001;
         end
      end
   end

   // broadcast at each second rollover, only in bus-only mode
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         bcast_valid_out <= 1'b0;
         bcast_time_out  <= '0;
      end else begin
         bcast_valid_out <= (mode_in == cmdt_pkg::CMDT_BUS_ONLY) && sec_roll;
         if (sec_roll) begin
            bcast_time_out <= next_ms(now);
         end
      end
   end

   // event time stamp from the local calendar
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         stamp_valid_out <= 1'b0;
         stamp_out       <= '0;
      end else begin
         stamp_valid_out <= event_in;
         if (event_in) begin
            stamp_out <= now;
         end
      end
   end

   // checks
   AST_BUSY_STATUS: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      state == cmdt_pkg::CMDT_BUSY |-> result == `CMDT_STATUS_BUSY)
      else $error("status not busy while executing");
   AST_ACCEPT_BUSY: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      accept |=> state == cmdt_pkg::CMDT_BUSY ##1 state == cmdt_pkg::CMDT_DONE)
      else $error("accepted command did not run in order");
   AST_EXEC_CODE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      state == cmdt_pkg::CMDT_BUSY |=> exec_code == $past(cmd_buf[0]))
      else $error("executed code differs from buffer");
   AST_SUCCESS_LOW: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      cmd_done_out && data_len == `CMDT_TIME_DATA_LEN |-> result[7:0] == `CMDT_ERR_NONE)
      else $error("success with nonzero result byte");
   AST_RANGE_ERR: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      state == cmdt_pkg::CMDT_BUSY && cmd_buf[0] == `CMDT_CODE_READ_TIME
      && cmd_buf[1] != `CMDT_FIXED_LEN |=> result[7:0] == `CMDT_ERR_RANGE)
      else $error("bad length not reported as error 15");
   AST_DATA_LEN: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      state == cmdt_pkg::CMDT_BUSY && next_err == `CMDT_ERR_NONE
      |=> data_len == `CMDT_TIME_DATA_LEN && snap == $past(now))
      else $error("data length or snapshot wrong on success");
   AST_MONTH_DAY: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      reg_rd_in && reg_num_in == `CMDT_REG_MONTH_DAY
      |=> reg_rvalid_out && reg_rdata_out == {$past(snap.month), $past(snap.day)})
      else $error("month/day read wrong");
   AST_SYNC_SET: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      set_req |=> synced_out && sync_age == 13'h0000)
      else $error("set did not mark synchronized");
   AST_BCAST_MODE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      bcast_valid_out |-> $past(mode_in) == cmdt_pkg::CMDT_BUS_ONLY && $past(sec_roll))
      else $error("broadcast outside bus-only second");
   AST_STAMP: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      event_in |=> stamp_valid_out && stamp_out == $past(now))
      else $error("event stamp wrong");

   // completion timing, result holding and window lapse
   AST_DONE_PULSE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      cmd_done_out |=> !cmd_done_out && state == cmdt_pkg::CMDT_IDLE)
      else $error("done not a single cycle before idle");
   AST_RESULT_STABLE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      state == cmdt_pkg::CMDT_IDLE && !accept |=> $stable(result) && $stable(data_len))
      else $error("result changed outside completion");
   AST_ERR_UNKNOWN: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      state == cmdt_pkg::CMDT_BUSY && cmd_buf[0] != `CMDT_CODE_READ_TIME
      |=> result[7:0] != `CMDT_ERR_NONE && data_len == 16'h0000)
      else $error("unknown command reported as success");
   AST_SYNC_LAPSE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      synced_out && !set_req && sec_roll && sync_age == 13'(SYNC_SECONDS - 1) |=> !synced_out)
      else $error("synchronized state outlived its window");
   AST_BCAST_TIME: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      bcast_valid_out |-> bcast_time_out.msec == 16'h0000)
      else $error("broadcast time not on a second boundary");

endmodule // cmdt_mailbox

`default_nettype wire

/* cmdt_regs.svh */
// register numbers, constants and timing counts of the date/time command mailbox
`ifndef CMDT_REGS_SVH
`define CMDT_REGS_SVH

// register numbers as seen by the client
`define CMDT_REG_CMD_BASE    16'h1F40
`define CMDT_REG_CMD_LAST    16'h1F53
`define CMDT_REG_EXEC_CODE   16'h1F54
`define CMDT_REG_RESULT      16'h1F55
`define CMDT_REG_DATA_LEN    16'h1F56
`define CMDT_REG_MONTH_DAY   16'h1F57
`define CMDT_REG_YEAR_HOUR   16'h1F58
`define CMDT_REG_MIN_SEC     16'h1F59
`define CMDT_REG_MSEC        16'h1F5A
`define CMDT_BUF_WORDS       5'h14

// command buffer contents
`define CMDT_CODE_READ_TIME  16'h0300
`define CMDT_FIXED_LEN       16'h000A
`define CMDT_DEST_SERIAL     16'h0300
`define CMDT_DEST_ETHERNET   16'h2200
`define CMDT_SETUP_0         16'h1F53
`define CMDT_SETUP_1         16'h1F54
`define CMDT_SETUP_2         16'h1F55

// result codes
`define CMDT_STATUS_BUSY     16'h0003
`define CMDT_ERR_NONE        8'h00
`define CMDT_ERR_RANGE       8'h0F
`define CMDT_ERR_UNKNOWN     8'h0E
`define CMDT_TIME_DATA_LEN   16'h0008

// timing: clock period, millisecond and sync window
`define CMDT_CLK_NS          50
`define CMDT_MS_NS           1000000
`define CMDT_MS_CYCLES       (`CMDT_MS_NS / `CMDT_CLK_NS)
`define CMDT_SYNC_HOURS      2
`define CMDT_SYNC_SECONDS    (`CMDT_SYNC_HOURS * 3600)
`define CMDT_MS_MAX          16'h03E7

`endif

/* cmdt_pkg.sv */
// types shared by the date/time command mailbox
package cmdt_pkg;

   // calendar value, year is offset from 2000
   typedef struct packed {
      logic [7:0]  year;
      logic [7:0]  month;
      logic [7:0]  day;
      logic [7:0]  hour;
      logic [7:0]  minute;
      logic [7:0]  second;
      logic [15:0] msec;
   } cmdt_time_t;

   // operating mode of the breaker status module
   typedef enum logic [1:0] {
      CMDT_BUS_ONLY       = 2'h0,
      CMDT_SERIAL_ONLY    = 2'h1,
      CMDT_SERIAL_AND_BUS = 2'h2
   } cmdt_mode_t;

   // command sequencer states
   typedef enum logic [2:0] {
      CMDT_IDLE = 3'b001,
      CMDT_BUSY = 3'b010,
      CMDT_DONE = 3'b100
   } cmdt_state_t;

endpackage

/* cmdt_client.sv */
// client model that drives the mailbox register port
`include "cmdt_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module cmdt_client (
   input  wire logic        clock_in,
   input  wire logic [15:0] rdata_in,
   input  wire logic        rvalid_in,
   output var  logic        wr_out,
   output var  logic        rd_out,
   output var  logic [15:0] num_out,
   output var  logic [15:0] wdata_out
);
   // idle bus at time zero
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      num_out = 16'h0000;
      wdata_out = 16'h0000;
   end

   // one burst of 20 words from the buffer base; wr stays up for the next read
   task automatic send_buf(input logic [15:0] code, len, dest, setup0);
      for (int i = 0; i < 20; i++) begin
         @(negedge clock_in);
         wr_out    <= 1'b1;
         num_out   <= `CMDT_REG_CMD_BASE + 16'(i);
         wdata_out <= (i == 0) ? code : (i == 1) ? len : (i == 2) ? dest :
                      (i >= 17) ? setup0 + 16'(i - 17) : 16'h0000;
      end
   endtask

   // single read; data stays unknown if no answer comes
   task automatic read_reg(input logic [15:0] num, output logic [15:0] data);
      data = 16'hxxxx;
      @(negedge clock_in);
      wr_out  <= 1'b0;
      rd_out  <= 1'b1;
      num_out <= num;
      @(negedge clock_in);
      rd_out    <= 1'b0;
      num_out   <= ~num; // released lines do not keep the old value
      wdata_out <= ~wdata_out;
      // the answer stands for one cycle only, so look before waiting again
      for (int i = 0; i < 4; i++) begin
         if (rvalid_in === 1'b1) begin
            data = rdata_in;
            break;
         end
         @(negedge clock_in);
      end
   endtask

   // submit, poll while in progress (bounded), restart once on a foreign code
   task automatic run_cmd(input logic [15:0] code, len, dest, setup0,
                          output logic [15:0] first, last, exec);
      for (int t = 0; t < 2; t++) begin
         send_buf(code, len, dest, setup0);
         read_reg(`CMDT_REG_RESULT, first);
         last = first;
         for (int i = 0; i < 8 && last === `CMDT_STATUS_BUSY; i++)
            read_reg(`CMDT_REG_RESULT, last);
         read_reg(`CMDT_REG_EXEC_CODE, exec);
         if (exec === code) break;
      end
   endtask
endmodule // cmdt_client
`default_nettype wire

/* cmd_mailbox_date_time_read_bench.sv */
// self-checking bench of the date/time command mailbox
`include "cmdt_regs.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("unexpected %s expected %h seen %h", what, exp, got); \
      end \
   end
module cmd_mailbox_date_time_read_bench;
   localparam int unsigned MS  = 4;
   localparam int unsigned SYN = 3;
   logic                 clock_in = 1'b0;
   logic                 rst_n_in = 1'b0;
   logic                 wr, rd, rvalid, done, synced, bvalid, svalid;
   logic                 set_fc43 = 1'b0, set_abs = 1'b0, event_in = 1'b0;
   logic [15:0]          num, wdata, rdata;
   cmdt_pkg::cmdt_mode_t mode = cmdt_pkg::CMDT_BUS_ONLY;
   cmdt_pkg::cmdt_time_t set_value = '0, exp_t, got_t, btime, stamp;
   logic [31:0]          seed = 32'hf7a3_0980;
   int                   errors = 0, cmp_count = 0;

   always #25 clock_in = ~clock_in;

   cmdt_client cli (.clock_in(clock_in), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
      .rd_out(rd), .num_out(num), .wdata_out(wdata));

   cmdt_mailbox #(.MS_CYCLES(MS), .SYNC_SECONDS(SYN)) dut (.clock_in(clock_in),
      .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_num_in(num),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .cmd_done_out(done), .set_fc43_in(set_fc43), .set_abs_in(set_abs),
      .set_value_in(set_value), .mode_in(mode), .synced_out(synced),
      .bcast_valid_out(bvalid), .bcast_time_out(btime), .event_in(event_in),
      .stamp_valid_out(svalid), .stamp_out(stamp));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] pick(input int unsigned lo, input int unsigned span);
      seed = lfsr(seed);
      return 8'(lo + seed % span);
   endfunction

   // random calendar loaded through one of the two set strobes
   task automatic set_time(input logic abs, input logic [15:0] ms);
      exp_t = {pick(0, 100), pick(1, 12), pick(1, 28), pick(0, 24), pick(0, 60), pick(0, 58), ms};
      @(negedge clock_in);
      set_value <= exp_t;
      set_fc43  <= ~abs;
      set_abs   <= abs;
      @(negedge clock_in);
      set_fc43  <= 1'b0;
      set_abs   <= 1'b0;
      `CHK("synced", 1'b1, synced)
   endtask

   // calendar against the model, a few elapsed milliseconds allowed
   task automatic check_time(input string what, input cmdt_pkg::cmdt_time_t got);
      `CHK(what, exp_t[63:16], got[63:16])
      `CHK(what, 1'b1, got.msec >= exp_t.msec && got.msec <= exp_t.msec + 16'h0028)
   endtask

   // one command; expected error worked out from the buffer contents
   task automatic command(input logic [15:0] code, len, dest, setup0);
      logic [15:0] first, last, exec, dlen;
      logic [7:0]  err;
      err = (code != `CMDT_CODE_READ_TIME) ? `CMDT_ERR_UNKNOWN :
            (len != `CMDT_FIXED_LEN || dest != `CMDT_DEST_SERIAL || setup0 != `CMDT_SETUP_0)
            ? `CMDT_ERR_RANGE : `CMDT_ERR_NONE;
      cli.run_cmd(code, len, dest, setup0, first, last, exec);
      `CHK("busy status", `CMDT_STATUS_BUSY, first)
      `CHK("executed code", code, exec)
      `CHK("result", {dest[15:8], err}, last)
      cli.read_reg(`CMDT_REG_DATA_LEN, dlen);
      `CHK("data length", (err == 8'h00) ? `CMDT_TIME_DATA_LEN : 16'h0000, dlen)
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // cuts a hang short
   initial begin
      repeat (100000) @(posedge clock_in);
      errors++;
      close_out();
   end

   // main sequence
   initial begin
      logic [15:0] md, yh, mn, ms;
      int n;
      repeat (4) @(negedge clock_in);
      rst_n_in = 1'b1;
      `CHK("synced after reset", 1'b0, synced)
      cli.read_reg(`CMDT_REG_RESULT, md);
      `CHK("status after reset", 16'h0000, md)
      set_time(1'b0, {6'h00, pick(0, 225), 2'b00});
      command(`CMDT_CODE_READ_TIME, `CMDT_FIXED_LEN, `CMDT_DEST_SERIAL, `CMDT_SETUP_0);
      cli.read_reg(`CMDT_REG_MONTH_DAY, md);
      cli.read_reg(`CMDT_REG_YEAR_HOUR, yh);
      cli.read_reg(`CMDT_REG_MIN_SEC, mn);
      cli.read_reg(`CMDT_REG_MSEC, ms);
      check_time("date registers", {yh[15:8], md, yh[7:0], mn, ms});
      // faulty buffers: unknown code, long parameters, other destination, bad setup
      command(16'h0301, `CMDT_FIXED_LEN, `CMDT_DEST_SERIAL, `CMDT_SETUP_0);
      command(`CMDT_CODE_READ_TIME, 16'h000B, `CMDT_DEST_SERIAL, `CMDT_SETUP_0);
      command(`CMDT_CODE_READ_TIME, `CMDT_FIXED_LEN, `CMDT_DEST_ETHERNET, `CMDT_SETUP_0);
      command(`CMDT_CODE_READ_TIME, `CMDT_FIXED_LEN, `CMDT_DEST_SERIAL, 16'h1F52);
      // periodic refresh, then an event stamped with the own calendar
      set_time(1'b1, 16'h0064);
      event_in <= 1'b1;
      @(negedge clock_in);
      event_in <= 1'b0;
      `CHK("stamp valid", 1'b1, svalid)
      check_time("stamp", stamp);
      // second rollover is broadcast only when this interface is the sync source
      for (int m = 0; m < 3; m++) begin
         mode <= cmdt_pkg::cmdt_mode_t'(m);
         set_time(1'b0, `CMDT_MS_MAX);
         n = 0;
         got_t = '0;
         for (int c = 0; c < MS * 500; c++) begin
            @(negedge clock_in);
            if (bvalid === 1'b1) begin
               if (n == 0) got_t = btime;
               n++;
            end
         end
         exp_t.second = exp_t.second + 8'h01;
         exp_t.msec = 16'h0000;
         `CHK("broadcast count", (m == 0) ? 1 : 0, n)
         if (m == 0) `CHK("broadcast time", exp_t, got_t)
      end
      // synchronized state lapses once the last set is SYN seconds old
      set_time(1'b0, 16'h0000);
      repeat (SYN * MS * 1000 - MS * 100) @(negedge clock_in);
      `CHK("synced inside window", 1'b1, synced)
      for (n = 0; n < 2 * MS * 1000 && synced === 1'b1; n++) @(negedge clock_in);
      `CHK("synced after window", 1'b0, synced)
      `CHK("lapse delay", 1'b1, n < MS * 200)
      close_out();
   end
endmodule // cmd_mailbox_date_time_read_bench
`default_nettype wire
